// ===== hw/cct_pkg.sv
// Package of offsets, field positions, reset values and counts for the conversion timing block.
package cct_pkg;
    // ========================================
    // Register map
    // ========================================
    localparam int unsigned ADDR_W       = 5;
    localparam logic [4:0]  OFS_CTRL     = 5'h00;
    localparam logic [4:0]  OFS_TX_A     = 5'h04;
    localparam logic [4:0]  OFS_TX_B     = 5'h08;
    localparam logic [4:0]  OFS_RX_A     = 5'h0c;
    localparam logic [4:0]  OFS_RX_B     = 5'h10;
    localparam logic [4:0]  OFS_TX_TRIM  = 5'h14;
    localparam logic [4:0]  OFS_RX_TRIM  = 5'h18;
    localparam logic [4:0]  OFS_STATUS   = 5'h1c;

    // ========================================
    // Control fields
    // ========================================
    localparam int unsigned CTRL_W       = 6;
    localparam int unsigned BIT_AUX      = 0;
    localparam int unsigned BIT_GAIN_LO  = 1;
    localparam int unsigned BIT_GAIN_HI  = 2;
    localparam int unsigned BIT_BYPASS   = 3;
    localparam int unsigned BIT_SYNC     = 4;
    localparam int unsigned BIT_STYLE    = 5;
    localparam logic [1:0]  GAIN_X1      = 2'h0;
    localparam logic [1:0]  GAIN_X2      = 2'h1;
    localparam logic [1:0]  GAIN_X4      = 2'h2;
    localparam logic [5:0]  CTRL_RST     = 6'h30;

    // ========================================
    // Rates and default divider values
    // ========================================
    localparam int unsigned MCLK_HZ      = 5184000;
    localparam int unsigned FILTER_HZ    = 288000;
    localparam int unsigned CONV_HZ      = 8000;
    localparam int unsigned DIV_A_RST    = MCLK_HZ / FILTER_HZ;
    localparam int unsigned DIV_B_RST    = FILTER_HZ / CONV_HZ;
    localparam int unsigned TRIM_RST     = 1;
    localparam int unsigned SHIFT_DIV    = 4;

    // ========================================
    // Serial-port modes
    // ========================================
    typedef enum logic [1:0] {
        CCT_MODE_ASYNC_BYTE,
        CCT_MODE_ASYNC_WORD,
        CCT_MODE_SYNC_BYTE,
        CCT_MODE_SYNC_WORD
    } cct_mode_e;
endpackage : cct_pkg

// ===== hw/cct_divider.sv
// Reloading divider that turns input ticks into one-cycle enable pulses.
`timescale 1ns/1ps
module cct_divider #(
    parameter int unsigned W        = 8,
    parameter int unsigned RST_LOAD = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic         hold,
    input  wire logic [W-1:0] load_val,
    output logic              pulse
);
    // ========================================
    // Parameter check
    // ========================================
    if (W < 2 || RST_LOAD >= (1 << W)) begin : g_bad
        $error("cct_divider parameters out of range");
    end

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         pulse_q;
    logic         pulse_d;

    // ========================================
    // Count down, reload at terminal count
    // ========================================
    // A programmed zero acts as one so the divider never stalls.
    always_comb begin
        cnt_d   = cnt_q;
        pulse_d = 1'b0;
        if (hold) begin
            cnt_d = load_val;
        end else if (tick) begin
            if (cnt_q <= W'(1)) begin
                cnt_d   = load_val;
                pulse_d = 1'b1;
            end else begin
                cnt_d = cnt_q - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= W'(RST_LOAD);
            pulse_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse = pulse_q;
endmodule : cct_divider

// ===== hw/cct_input_route.sv
// Registered analog input routing, gain and filter path controls.
`timescale 1ns/1ps
module cct_input_route (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       aux_sel,
    input  wire logic [1:0] gain_code,
    input  wire logic       bypass,
    output logic            route_aux,
    output logic            gain_x2,
    output logic            gain_x4,
    output logic            filter_in_path
);
    logic [3:0] sel_q;
    logic [3:0] sel_d;

    // ========================================
    // Decode
    // ========================================
    always_comb begin
        sel_d[0] = aux_sel;
        sel_d[1] = (gain_code == cct_pkg::GAIN_X2);
        sel_d[2] = (gain_code == cct_pkg::GAIN_X4);
        sel_d[3] = !bypass;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 4'h8;
        end else begin
            sel_q <= sel_d;
        end
    end

    assign route_aux      = sel_q[0];
    assign gain_x2        = sel_q[1];
    assign gain_x4        = sel_q[2];
    assign filter_in_path = sel_q[3];
endmodule : cct_input_route

// ===== hw/cct_timing.sv
// Control and conversion timing of the analog interface unit.
//
// Contract
// - Route the primary input pair by default, or the auxiliary pair when software selects it.
// - Apply one of exactly three software-chosen input gains: 1, 2 or 4.
// - Insert or bypass the receive bandpass filter as software sets.
// - Derive the receive filter clock from the master clock by a programmable receive first divider.
// - Derive the A/D strobe from the receive filter clock by a second receive divider, locked to it.
// - Derive the D/A strobe from the transmit filter clock by a second transmit divider, locked to it.
// - In asynchronous operation generate both filter clocks and both conversion rates independently.
// - In synchronous operation the transmit filter clock drives both filters and the receive first divider idles.
// - In synchronous operation the A/D timing equals the D/A timing in rate and instant.
// - Offer four serial-port modes combining async or sync operation with one of two framing styles.
// - In synchronous mode with the second framing style, flag use with external shift registers.
// - Produce the serial bit clock as the master clock divided by four.
// - On reset load dividers that give 8 kHz conversion from a 5.184 MHz master clock.
// - On reset set both conversion-rate trims to one.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module cct_timing #(
    parameter int unsigned DIV_W  = 8,
    parameter int unsigned TRIM_W = 8
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic [cct_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    output logic                            route_aux,
    output logic                            gain_x2,
    output logic                            gain_x4,
    output logic                            filter_in_path,
    output logic                            tx_filter_clk_en,
    output logic                            rx_filter_clk_en,
    output logic                            dac_strobe,
    output logic                            adc_strobe,
    output logic                            shift_clk,
    output logic                            shift_clk_en,
    output logic                            sync_mode,
    output logic      [1:0]                 serial_mode,
    output logic                            shift_reg_port
);
    localparam int unsigned BW = DIV_W + 1;

    // ========================================
    // Parameter check
    // ========================================
    if (DIV_W < 6 || DIV_W > 16 || TRIM_W < 1 || TRIM_W > DIV_W ||
        cct_pkg::DIV_B_RST >= (1 << DIV_W)) begin : g_bad
        $error("cct_timing parameters out of range");
    end

    // ========================================
    // Software-visible state
    // ========================================
    logic [cct_pkg::CTRL_W-1:0] ctrl_q;
    logic [cct_pkg::CTRL_W-1:0] ctrl_d;
    logic [DIV_W-1:0]           tx_a_q;
    logic [DIV_W-1:0]           tx_a_d;
    logic [DIV_W-1:0]           tx_b_q;
    logic [DIV_W-1:0]           tx_b_d;
    logic [DIV_W-1:0]           rx_a_q;
    logic [DIV_W-1:0]           rx_a_d;
    logic [DIV_W-1:0]           rx_b_q;
    logic [DIV_W-1:0]           rx_b_d;
    logic [TRIM_W-1:0]          tx_rate_trim_q;
    logic [TRIM_W-1:0]          tx_rate_trim_d;
    logic [TRIM_W-1:0]          rx_rate_trim_q;
    logic [TRIM_W-1:0]          rx_rate_trim_d;
    logic [31:0]                rdata_q;
    logic [31:0]                rdata_d;
    logic [15:0]                dac_count_q;
    logic [15:0]                dac_count_d;
    logic [15:0]                adc_count_q;
    logic [15:0]                adc_count_d;

    // ========================================
    // Divider chain signals
    // ========================================
    logic                       tx_a_pulse;
    logic                       rx_a_pulse;
    logic                       tx_b_pulse;
    logic                       rx_b_pulse;
    logic [BW-1:0]              tx_b_load;
    logic [BW-1:0]              rx_b_load;
    logic                       rx_b_tick;
    logic                       is_sync;
    cct_pkg::cct_mode_e         mode;
    logic [1:0]                 shift_phase_q;
    logic [1:0]                 shift_phase_d;
    logic                       shift_clk_q;
    logic                       shift_clk_d;
    logic                       shift_en_q;
    logic                       shift_en_d;

    assign is_sync = ctrl_q[cct_pkg::BIT_SYNC];

    // ========================================
    // Register writes and read data
    // ========================================
    // A gain code outside the three legal settings is ignored, the old gain stays.
    always_comb begin
        ctrl_d         = ctrl_q;
        tx_a_d         = tx_a_q;
        tx_b_d         = tx_b_q;
        rx_a_d         = rx_a_q;
        rx_b_d         = rx_b_q;
        tx_rate_trim_d = tx_rate_trim_q;
        rx_rate_trim_d = rx_rate_trim_q;
        rdata_d        = 32'h0000_0000;
        // A trim is spent by the conversion period it lengthens; a write in that cycle wins.
        if (tx_b_pulse) begin
            tx_rate_trim_d = TRIM_W'(cct_pkg::TRIM_RST);
        end
        if (rx_b_pulse) begin
            rx_rate_trim_d = TRIM_W'(cct_pkg::TRIM_RST);
        end
        if (reg_wr) begin
            unique case (reg_addr)
                cct_pkg::OFS_CTRL: begin
                    ctrl_d[cct_pkg::BIT_AUX]    = reg_wdata[cct_pkg::BIT_AUX];
                    ctrl_d[cct_pkg::BIT_BYPASS] = reg_wdata[cct_pkg::BIT_BYPASS];
                    ctrl_d[cct_pkg::BIT_SYNC]   = reg_wdata[cct_pkg::BIT_SYNC];
                    ctrl_d[cct_pkg::BIT_STYLE]  = reg_wdata[cct_pkg::BIT_STYLE];
                    if (reg_wdata[cct_pkg::BIT_GAIN_HI:cct_pkg::BIT_GAIN_LO] != 2'h3) begin
                        ctrl_d[cct_pkg::BIT_GAIN_HI:cct_pkg::BIT_GAIN_LO] =
                            reg_wdata[cct_pkg::BIT_GAIN_HI:cct_pkg::BIT_GAIN_LO];
                    end
                end
                cct_pkg::OFS_TX_A: begin
                    tx_a_d = reg_wdata[DIV_W-1:0];
                end
                cct_pkg::OFS_TX_B: begin
                    tx_b_d = reg_wdata[DIV_W-1:0];
                end
                cct_pkg::OFS_RX_A: begin
                    rx_a_d = reg_wdata[DIV_W-1:0];
                end
                cct_pkg::OFS_RX_B: begin
                    rx_b_d = reg_wdata[DIV_W-1:0];
                end
                cct_pkg::OFS_TX_TRIM: begin
                    tx_rate_trim_d = reg_wdata[TRIM_W-1:0];
                end
                cct_pkg::OFS_RX_TRIM: begin
                    rx_rate_trim_d = reg_wdata[TRIM_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                cct_pkg::OFS_CTRL:    rdata_d = 32'(ctrl_q);
                cct_pkg::OFS_TX_A:    rdata_d = 32'(tx_a_q);
                cct_pkg::OFS_TX_B:    rdata_d = 32'(tx_b_q);
                cct_pkg::OFS_RX_A:    rdata_d = 32'(rx_a_q);
                cct_pkg::OFS_RX_B:    rdata_d = 32'(rx_b_q);
                cct_pkg::OFS_TX_TRIM: rdata_d = 32'(tx_rate_trim_q);
                cct_pkg::OFS_RX_TRIM: rdata_d = 32'(rx_rate_trim_q);
                cct_pkg::OFS_STATUS:  rdata_d = {adc_count_q, dac_count_q};
                default:              rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q         <= cct_pkg::CTRL_RST;
            tx_a_q         <= DIV_W'(cct_pkg::DIV_A_RST);
            tx_b_q         <= DIV_W'(cct_pkg::DIV_B_RST);
            rx_a_q         <= DIV_W'(cct_pkg::DIV_A_RST);
            rx_b_q         <= DIV_W'(cct_pkg::DIV_B_RST);
            tx_rate_trim_q <= TRIM_W'(cct_pkg::TRIM_RST);
            rx_rate_trim_q <= TRIM_W'(cct_pkg::TRIM_RST);
            rdata_q        <= 32'h0000_0000;
        end else begin
            ctrl_q         <= ctrl_d;
            tx_a_q         <= tx_a_d;
            tx_b_q         <= tx_b_d;
            rx_a_q         <= rx_a_d;
            rx_b_q         <= rx_b_d;
            tx_rate_trim_q <= tx_rate_trim_d;
            rx_rate_trim_q <= rx_rate_trim_d;
            rdata_q        <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ========================================
    // Conversion period with one-shot trim
    // ========================================
    // The trim stretches, keeps or, at zero, shortens the next period only: length is base plus trim minus one.
    always_comb begin
        tx_b_load = BW'(tx_b_q) + BW'(tx_rate_trim_q) - BW'(1);
        rx_b_load = BW'(rx_b_q) + BW'(rx_rate_trim_q) - BW'(1);
    end

    // ========================================
    // Transmit chain
    // ========================================
    cct_divider #(
        .W        (DIV_W),
        .RST_LOAD (cct_pkg::DIV_A_RST)
    ) u_tx_a (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .tick     (1'b1),
        .hold     (1'b0),
        .load_val (tx_a_q),
        .pulse    (tx_a_pulse)
    );

    cct_divider #(
        .W        (BW),
        .RST_LOAD (cct_pkg::DIV_B_RST)
    ) u_tx_b (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .tick     (tx_a_pulse),
        .hold     (1'b0),
        .load_val (tx_b_load),
        .pulse    (tx_b_pulse)
    );

    // ========================================
    // Receive chain
    // ========================================
    // In sync operation the receive first divider is held idle so it burns no toggles.
    cct_divider #(
        .W        (DIV_W),
        .RST_LOAD (cct_pkg::DIV_A_RST)
    ) u_rx_a (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .tick     (1'b1),
        .hold     (is_sync),
        .load_val (rx_a_q),
        .pulse    (rx_a_pulse)
    );

    assign rx_b_tick = is_sync ? 1'b0 : rx_a_pulse;

    cct_divider #(
        .W        (BW),
        .RST_LOAD (cct_pkg::DIV_B_RST)
    ) u_rx_b (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .tick     (rx_b_tick),
        .hold     (is_sync),
        .load_val (rx_b_load),
        .pulse    (rx_b_pulse)
    );

    // ========================================
    // Section clock selection
    // ========================================
    always_comb begin
        tx_filter_clk_en = tx_a_pulse;
        dac_strobe       = tx_b_pulse;
        if (is_sync) begin
            rx_filter_clk_en = tx_a_pulse;
            adc_strobe       = tx_b_pulse;
        end else begin
            rx_filter_clk_en = rx_a_pulse;
            adc_strobe       = rx_b_pulse;
        end
    end

    // ========================================
    // Conversion counters for status
    // ========================================
    always_comb begin
        dac_count_d = dac_strobe ? dac_count_q + 16'h0001 : dac_count_q;
        adc_count_d = adc_strobe ? adc_count_q + 16'h0001 : adc_count_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_count_q <= 16'h0000;
            adc_count_q <= 16'h0000;
        end else begin
            dac_count_q <= dac_count_d;
            adc_count_q <= adc_count_d;
        end
    end

    // ========================================
    // Serial bit clock
    // ========================================
    // A fixed divide by four keeps the bit clock square without a programmable path.
    always_comb begin
        shift_phase_d = shift_phase_q + 2'h1;
        shift_clk_d   = (shift_phase_d < 2'(cct_pkg::SHIFT_DIV / 2));
        shift_en_d    = (shift_phase_d == 2'h0);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_phase_q <= 2'h3;
            shift_clk_q   <= 1'b0;
            shift_en_q    <= 1'b0;
        end else begin
            shift_phase_q <= shift_phase_d;
            shift_clk_q   <= shift_clk_d;
            shift_en_q    <= shift_en_d;
        end
    end

    assign shift_clk    = shift_clk_q;
    assign shift_clk_en = shift_en_q;

    // ========================================
    // Serial mode
    // ========================================
    always_comb begin
        mode = cct_pkg::cct_mode_e'({ctrl_q[cct_pkg::BIT_SYNC], ctrl_q[cct_pkg::BIT_STYLE]});
    end

    assign sync_mode      = is_sync;
    assign serial_mode    = mode;
    assign shift_reg_port = (mode == cct_pkg::CCT_MODE_SYNC_WORD);

    // ========================================
    // Analog front-end selects
    // ========================================
    cct_input_route u_route (
        .clk            (sys_clk),
        .rst_n          (rst_n),
        .aux_sel        (ctrl_q[cct_pkg::BIT_AUX]),
        .gain_code      (ctrl_q[cct_pkg::BIT_GAIN_HI:cct_pkg::BIT_GAIN_LO]),
        .bypass         (ctrl_q[cct_pkg::BIT_BYPASS]),
        .route_aux      (route_aux),
        .gain_x2        (gain_x2),
        .gain_x4        (gain_x4),
        .filter_in_path (filter_in_path)
    );
endmodule : cct_timing

// ===== tb/cct_timing_sva.sv
// Checker of the timing and mode outputs of the conversion timing block.
`timescale 1ns/1ps
module cct_timing_chk (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       tx_filter_clk_en,
    input wire logic       rx_filter_clk_en,
    input wire logic       dac_strobe,
    input wire logic       adc_strobe,
    input wire logic       shift_clk,
    input wire logic       shift_clk_en,
    input wire logic       sync_mode,
    input wire logic [1:0] serial_mode,
    input wire logic       shift_reg_port,
    input wire logic       gain_x2,
    input wire logic       gain_x4
);
    // ========================================
    // Assertions
    // ========================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_sen; shift_clk_en |-> $rose(shift_clk); endproperty
    a_sen: assert property (p_sen) else $error("bit clock enable off its rise");
    property p_swave; $rose(shift_clk) |=> shift_clk ##1 !shift_clk ##1 !shift_clk ##1 shift_clk; endproperty
    a_swave: assert property (p_swave) else $error("bit clock not two high two low");
    property p_dac; dac_strobe |-> $past(tx_filter_clk_en); endproperty
    a_dac: assert property (p_dac) else $error("dac strobe not after tx filter tick");
    // The receive mux swaps source when sync turns on, so the cycle of the swap is left out.
    property p_adc; adc_strobe && $stable(sync_mode) |-> $past(rx_filter_clk_en); endproperty
    a_adc: assert property (p_adc) else $error("adc strobe not after rx filter tick");
    property p_sync; sync_mode [*3] |-> adc_strobe == dac_strobe && rx_filter_clk_en == tx_filter_clk_en; endproperty
    a_sync: assert property (p_sync) else $error("sync timing differs");
    property p_gain; !(gain_x2 && gain_x4); endproperty
    a_gain: assert property (p_gain) else $error("two gains at once");
    property p_mode; serial_mode[1] == sync_mode; endproperty
    a_mode: assert property (p_mode) else $error("mode and sync disagree");
    property p_sreg; shift_reg_port == (serial_mode == 2'h3); endproperty
    a_sreg: assert property (p_sreg) else $error("shift register port flag wrong");
endmodule : cct_timing_chk

bind cct_timing cct_timing_chk chk (.sys_clk(sys_clk), .rst_n(rst_n), .tx_filter_clk_en(tx_filter_clk_en),
    .rx_filter_clk_en(rx_filter_clk_en), .dac_strobe(dac_strobe), .adc_strobe(adc_strobe),
    .shift_clk(shift_clk), .shift_clk_en(shift_clk_en), .sync_mode(sync_mode), .serial_mode(serial_mode),
    .shift_reg_port(shift_reg_port), .gain_x2(gain_x2), .gain_x4(gain_x4));

// ===== tb/cct_host_port.sv
// Host serial port model that follows the bit clock.
`timescale 1ns/1ps
module cct_host_port #(
    parameter logic STYLE = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       shift_clk,
    input  wire logic [1:0] serial_mode,
    output int              bit_cnt,
    output logic            mode_ok
);
    // ========================================
    // Bit clock follower
    // ========================================
    logic sclk_q;
    // The host sees only the bit clock level, so the enable is not trusted here.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q  <= 1'b0;
            bit_cnt <= 0;
        end else begin
            sclk_q <= shift_clk;
            if (shift_clk && !sclk_q) begin
                bit_cnt <= bit_cnt + 1;
            end
        end
    end
    assign mode_ok = (serial_mode[0] === STYLE);
endmodule : cct_host_port

// ===== tb/tb_top.sv
// Self-checking testbench of the conversion timing block.
`timescale 1ns/1ps
module tb_top;
    // ========================================
    // Signals and instances
    // ========================================
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        route_aux, gain_x2, gain_x4, filter_in_path, tx_f, rx_f, dac_s, adc_s;
    logic        shift_clk, shift_clk_en, sync_mode, shift_reg_port, mode_ok;
    logic [1:0]  serial_mode;
    int          bit_cnt;
    int          error_cnt = 0;
    int          checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    cct_timing dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .route_aux(route_aux), .gain_x2(gain_x2),
        .gain_x4(gain_x4), .filter_in_path(filter_in_path), .tx_filter_clk_en(tx_f), .rx_filter_clk_en(rx_f),
        .dac_strobe(dac_s), .adc_strobe(adc_s), .shift_clk(shift_clk), .shift_clk_en(shift_clk_en),
        .sync_mode(sync_mode), .serial_mode(serial_mode), .shift_reg_port(shift_reg_port));
    cct_host_port host (.clk(sys_clk), .rst_n(rst_n), .shift_clk(shift_clk), .serial_mode(serial_mode),
        .bit_cnt(bit_cnt), .mode_ok(mode_ok));
    // ========================================
    // Shared tasks
    // ========================================
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask : wr
    task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        cmp(nm, e, reg_rdata);
    endtask : rd
    function automatic logic pick(input int s);
        case (s)
            0: return tx_f;
            1: return dac_s;
            2: return rx_f;
            default: return adc_s;
        endcase
    endfunction : pick
    // Waits for a pulse, then counts cycles to the next one; bounded against a stuck divider.
    task automatic per(input string nm, input int s, input int e);
        int p;
        p = 0;
        do @(negedge sys_clk); while (pick(s) !== 1'b1 && p++ < 2000);
        p = 0;
        do begin @(negedge sys_clk); p++; end while (pick(s) !== 1'b1 && p < 2000);
        if (nm != "") cmp(nm, e, p);
    endtask : per
    task automatic end_of_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    // ========================================
    // Scenarios
    // ========================================
    task automatic t_reset();
        rd("ctrl", cct_pkg::OFS_CTRL, 32'h30);
        rd("tx_a", cct_pkg::OFS_TX_A, 32'h12);
        rd("tx_b", cct_pkg::OFS_TX_B, 32'h24);
        rd("rx_a", cct_pkg::OFS_RX_A, 32'h12);
        rd("rx_b", cct_pkg::OFS_RX_B, 32'h24);
        rd("tx_trim", cct_pkg::OFS_TX_TRIM, 32'h1);
        rd("rx_trim", cct_pkg::OFS_RX_TRIM, 32'h1);
        rd("unmapped", 5'h01, 32'h0);
        cmp("aux", 0, route_aux);
        per("tx_filter", 0, 18);
        per("dac", 1, 648);
        per("adc", 3, 648);
    endtask : t_reset
    task automatic t_input();
        for (int g = 0; g < 4; g++) begin
            wr(cct_pkg::OFS_CTRL, 32'h30 | (g << 1) | (g & 1) | ((g & 1) << 3));
            cmp("aux", g & 1, route_aux);
            cmp("x2", g == 1, gain_x2);
            cmp("x4", g >= 2, gain_x4);
            cmp("filter", !(g & 1), filter_in_path);
        end
    endtask : t_input
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(cct_pkg::OFS_CTRL, ((m & 1) << 5) | ((m >> 1) << 4));
            cmp("mode", m, serial_mode);
            cmp("sync", m >> 1, sync_mode);
            cmp("sreg", m == 3, shift_reg_port);
            cmp("host", m & 1, mode_ok);
        end
    endtask : t_modes
    task automatic t_async_sync();
        wr(cct_pkg::OFS_CTRL, 32'h0);
        wr(cct_pkg::OFS_TX_A, 32'h3);
        wr(cct_pkg::OFS_TX_B, 32'h4);
        wr(cct_pkg::OFS_RX_A, 32'h5);
        wr(cct_pkg::OFS_RX_B, 32'h2);
        per("", 1, 0);
        per("", 3, 0);
        per("tx_filter", 0, 3);
        per("dac", 1, 12);
        // Written just after a strobe, the trim stretches only the period after the next strobe.
        wr(cct_pkg::OFS_TX_TRIM, 32'h3);
        per("trim", 1, 18);
        per("untrim", 1, 12);
        per("rx_filter", 2, 5);
        per("adc", 3, 10);
        wr(cct_pkg::OFS_CTRL, 32'h10);
        per("", 1, 0);
        per("rx_filter", 2, 3);
        per("adc", 3, 12);
    endtask : t_async_sync
    task automatic t_shift();
        int b0;
        @(negedge sys_clk);
        b0 = bit_cnt;
        repeat (400) @(negedge sys_clk);
        cmp("bits", 100, bit_cnt - b0);
    endtask : t_shift
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_input();
        t_modes();
        t_async_sync();
        t_shift();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        end_of_test();
    end
endmodule : tb_top
